// ---- core/tbcr_pkg.sv ----
// package for the timer count/capture data-path registers
// assumes a byte-wide register port with 4-bit offsets
package tbcr_pkg;
  localparam logic [3:0] OFS_STAGING  = 4'h9;
  localparam logic [3:0] OFS_CNT_LOW  = 4'ha;
  localparam logic [3:0] OFS_CNT_HIGH = 4'hb;
  localparam logic [3:0] OFS_CAPTURE_COMPARE_VALUE_LOW = 4'hc;
  localparam logic [3:0] OFS_CAPTURE_COMPARE_VALUE_HIGH = 4'hd;
  localparam logic [7:0]  RST_STAGING = 8'h00;
  localparam logic [15:0] RST_CNT     = 16'h0000;
  localparam logic [15:0] RST_CAPTURE_COMPARE_VALUE    = 16'h0000;
  // count mode encodings of count_mode_select
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT  = 3'h1;
  localparam logic [2:0] MODE_SINGLE   = 3'h6;
  localparam logic [2:0] MODE_PWM8     = 3'h7;
endpackage : tbcr_pkg

// ---- core/tbcr_regs.sv ----
// count and capture/compare registers of a 16-bit capture timer
// assumes mode/event control outside drives count, clear and capture strobes
`timescale 1ns/100ps
module tbcr_regs
  import tbcr_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] addr_in,
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic [2:0] count_mode_select_in,
  input  wire logic       count_step_in,
  input  wire logic       count_clear_in,
  input  wire logic       capture_event_in,
  input  wire logic       flag_write_one_in,
  output logic      [7:0] rdata_out,
  output logic      [15:0] counter_value_out,
  output logic      [15:0] capture_compare_value_out,
  output logic            at_top_out,
  output logic            capture_irq_flag_out
);
  logic       rst_meta_r;
  logic       rst_sync_r;
  logic [7:0] staging_r;
  logic [15:0] cnt_r;
  logic [15:0] capture_compare_value_r;
  logic [7:0] rdata_r;
  logic       top_r;
  logic       flag_r;

  // elaboration checks: the byte pairing below assumes each high byte sits
  // one offset above its low byte, and capture codes lie between timeout and single-shot
  if (OFS_CNT_HIGH != OFS_CNT_LOW + 4'h1) begin : g_cnt_pair_chk
    $error("counter high byte offset must follow its low byte");
  end
  if (OFS_CAPTURE_COMPARE_VALUE_HIGH != OFS_CAPTURE_COMPARE_VALUE_LOW + 4'h1) begin : g_capture_compare_value_pair_chk
    $error("compare high byte offset must follow its low byte");
  end
  if (MODE_SINGLE <= MODE_TIMEOUT + 3'h1) begin : g_mode_chk
    $error("capture mode codes need room between timeout and single-shot");
  end

  // reset released through two flops
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // address decode
  wire sel_stg  = addr_in == OFS_STAGING;
  wire sel_cl   = addr_in == OFS_CNT_LOW;
  wire sel_ch   = addr_in == OFS_CNT_HIGH;
  wire sel_ml   = addr_in == OFS_CAPTURE_COMPARE_VALUE_LOW;
  wire sel_mh   = addr_in == OFS_CAPTURE_COMPARE_VALUE_HIGH;
  wire is_pwm   = count_mode_select_in == MODE_PWM8;
  wire is_capture_irq_flag  = (count_mode_select_in > MODE_TIMEOUT) &&
                  (count_mode_select_in < MODE_SINGLE);
  wire is_topm  = !is_pwm && !is_capture_irq_flag;
  wire wr_stg   = wr_en_in && sel_stg;
  wire wr_cl    = wr_en_in && sel_cl;
  wire wr_ch    = wr_en_in && sel_ch;
  wire wr_ml    = wr_en_in && sel_ml;
  wire wr_mh    = wr_en_in && sel_mh;
  wire rd_cl    = rd_en_in && sel_cl;
  wire rd_ml    = rd_en_in && sel_ml;

  // hardware next count; clear wins over step, software wins over both
  wire [15:0] cnt_hw = count_clear_in ? RST_CNT :
                       count_step_in ? cnt_r + 16'h0001 : cnt_r;
  wire [15:0] cnt_nxt = wr_cl ? {staging_r, wdata_in} : cnt_hw;
  // pwm keeps the bytes apart, so the high byte is written directly
  wire [15:0] capture_compare_value_nxt =
      (is_capture_irq_flag && capture_event_in) ? cnt_r :
      (wr_ml && is_pwm)  ? {capture_compare_value_r[15:8], wdata_in} :
      wr_ml              ? {staging_r, wdata_in} :
      (wr_mh && is_pwm)  ? {wdata_in, capture_compare_value_r[7:0]} : capture_compare_value_r;
  wire pwm_match = is_pwm && (cnt_r[7:0] == capture_compare_value_r[7:0]);
  wire top_hit   = is_topm && (cnt_r == capture_compare_value_r);
  wire flag_set  = (is_capture_irq_flag && capture_event_in) || pwm_match || top_hit;
  wire flag_clr  = flag_write_one_in || (is_capture_irq_flag && rd_ml);
  // set wins over a clear in the same cycle, so a capture is never lost
  // a compare read outside capture modes leaves the flag alone
  wire flag_nxt  = flag_set || (flag_r && !flag_clr);
  // staging: software write, high-byte write, or low-byte read latch
  wire [7:0] stg_nxt =
      rd_cl ? cnt_r[15:8] :
      (rd_ml && !is_pwm) ? capture_compare_value_r[15:8] :
      (wr_ch || (wr_mh && !is_pwm) || wr_stg) ? wdata_in : staging_r;
  // high reads return staging, except pwm high byte which is independent
  wire [7:0] rd_mux =
      sel_stg ? staging_r :
      sel_cl  ? cnt_r[7:0] :
      sel_ch  ? staging_r :
      sel_ml  ? capture_compare_value_r[7:0] :
      sel_mh  ? (is_pwm ? capture_compare_value_r[15:8] : staging_r) : 8'h00;
  wire [7:0] rdata_nxt = rd_en_in ? rd_mux : rdata_r;

  // register update
  always_ff @(posedge ref_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      staging_r <= RST_STAGING;
      cnt_r     <= RST_CNT;
      capture_compare_value_r    <= RST_CAPTURE_COMPARE_VALUE;
      rdata_r   <= 8'h00;
      top_r     <= 1'b0;
      flag_r    <= 1'b0;
    end else begin
      staging_r <= stg_nxt;
      cnt_r     <= cnt_nxt;
      capture_compare_value_r    <= capture_compare_value_nxt;
      rdata_r   <= rdata_nxt;
      top_r     <= top_hit;
      flag_r    <= flag_nxt;
    end
  end

  assign rdata_out                 = rdata_r;
  assign counter_value_out         = cnt_r;
  assign capture_compare_value_out = capture_compare_value_r;
  assign at_top_out                = top_r;
  assign capture_irq_flag_out      = flag_r;

  // checks: all watch registered state one edge after the trigger; the disable on
  // the synchronised reset keeps them quiet until the release has settled
  // software counter write overrides the hardware update
  a_sw_write_wins: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    wr_cl |=> cnt_r == {$past(staging_r), $past(wdata_in)})
    else $error("counter write lost");
  a_clear_count: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (count_clear_in && !wr_cl) |=> cnt_r == RST_CNT)
    else $error("counter clear lost");
  a_step_count: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (count_step_in && !count_clear_in && !wr_cl) |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter step lost");
  // capture loads the counter and wins over a software compare write
  a_capture_load: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (is_capture_irq_flag && capture_event_in) |=> capture_compare_value_r == $past(cnt_r))
    else $error("capture did not load counter");
  // flag clears: write-one, or a compare read in capture modes; a set still wins
  a_flag_clear: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (flag_write_one_in && !flag_set) |=> !flag_r)
    else $error("flag not cleared");
  a_read_clear: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (is_capture_irq_flag && rd_ml && !flag_set) |=> !flag_r)
    else $error("capture read did not clear flag");
  // pwm flag follows the low byte match
  a_pwm_flag_set: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    pwm_match |=> flag_r)
    else $error("pwm match did not set flag");
  // staging: low reads latch the high byte, high writes and direct writes load it
  a_low_read_latch: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    rd_cl |=> staging_r == $past(cnt_r[15:8]))
    else $error("high byte not staged");
  a_capture_compare_value_low_latch: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (rd_ml && !is_pwm) |=> staging_r == $past(capture_compare_value_r[15:8]))
    else $error("compare high byte not staged");
  a_stage_write: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (wr_stg && !rd_en_in) |=> staging_r == $past(wdata_in))
    else $error("staging write lost");
  a_high_write_stage: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (wr_ch && !rd_en_in) |=> staging_r == $past(wdata_in))
    else $error("counter high byte not staged");
  a_high_read: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (rd_en_in && sel_ch) |=> rdata_out == $past(staging_r))
    else $error("high read did not return staging");
  a_capture_compare_value_commit: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (wr_ml && !is_pwm && !(is_capture_irq_flag && capture_event_in)) |=>
      capture_compare_value_r == {$past(staging_r), $past(wdata_in)})
    else $error("compare pair not committed");
  // top only exists in the periodic, timeout and single-shot modes
  a_top_flag: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    top_hit |=> flag_r && at_top_out)
    else $error("top not flagged");
  a_top_modes_only: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    !is_topm |=> !at_top_out)
    else $error("top shown outside top modes");
  // pwm bytes are written on their own
  a_pwm_indep: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (wr_mh && is_pwm && !capture_event_in) |=> capture_compare_value_r[15:8] == $past(wdata_in))
    else $error("pwm high byte not direct");
  a_pwm_low_indep: assert property (
    @(posedge ref_clk_in) disable iff (!rst_sync_r)
    (wr_ml && is_pwm) |=> capture_compare_value_r == {$past(capture_compare_value_r[15:8]), $past(wdata_in)})
    else $error("pwm low byte not direct");
  // main scenarios
  c_capture: cover property (@(posedge ref_clk_in) is_capture_irq_flag && capture_event_in);
  c_pair_write: cover property (@(posedge ref_clk_in) wr_ch ##2 wr_cl);
  c_pwm_match: cover property (@(posedge ref_clk_in) pwm_match);
  c_top_hit: cover property (@(posedge ref_clk_in) top_hit);
  c_flag_clear: cover property (@(posedge ref_clk_in) flag_r && flag_write_one_in);
endmodule : tbcr_regs

// ---- testbench/tb.sv ----
// testbench: register access, counter write priority, capture and pwm bytes
// assumes the cpu model on the register strobes; mode inputs driven here
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  import tbcr_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, step = 1'b0, ev = 1'b0;
  logic       clr = 1'b0, fw1 = 1'b0;
  logic [2:0] mode = MODE_PERIODIC;
  logic [3:0] addr;
  logic       wr, rd, top, flag;
  logic [7:0] wd, rdat, v;
  logic [15:0] cnt, capture_compare_value;
  int         n_errors = 0, samples_checked = 0, cyc = 0;
  tbcr_cpu_model u_cpu (.clk_in(clk), .addr_out(addr), .wr_en_out(wr), .rd_en_out(rd),
    .wdata_out(wd), .rdata_in(rdat));
  tbcr_regs DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wr_en_in(wr),
    .rd_en_in(rd), .wdata_in(wd), .count_mode_select_in(mode), .count_step_in(step),
    .count_clear_in(clr), .capture_event_in(ev), .flag_write_one_in(fw1),
    .rdata_out(rdat), .counter_value_out(cnt), .capture_compare_value_out(capture_compare_value),
    .at_top_out(top), .capture_irq_flag_out(flag));
  // 125 MHz clock; hang guard well above the few dozen cycles needed
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values of every mapped offset
    for (int a = 9; a <= 13; a++) begin
      u_cpu.rd(4'(a), v);
      `CHK(v, 8'h00)
    end
    // counter and compare both reset to zero, so periodic mode sits at top
    `CHK(top, 1'b1)
    `CHK(flag, 1'b1)
    u_cpu.wr(OFS_STAGING, 8'h3c);
    u_cpu.rd(OFS_STAGING, v);
    `CHK(v, 8'h3c)
    // low byte write lands while step and clear are both active; write must win
    @(posedge clk);
    step <= 1'b1;
    u_cpu.wr(OFS_CNT_HIGH, 8'haa);
    clr <= 1'b1;
    u_cpu.wr(OFS_CNT_LOW, 8'h55);
    step <= 1'b0;
    clr <= 1'b0;
    #1;
    `CHK(cnt, 16'haa55)
    u_cpu.rd(OFS_CNT_LOW, v);
    `CHK(v, 8'h55)
    u_cpu.rd(OFS_CNT_HIGH, v);
    `CHK(v, 8'haa)
    // counter now away from top: a write-one clears the flag
    `CHK(top, 1'b0)
    @(posedge clk);
    fw1 <= 1'b1;
    @(posedge clk);
    fw1 <= 1'b0;
    #1;
    `CHK(flag, 1'b0)
    // capture mode: event copies the counter, reading the capture clears the flag
    @(posedge clk);
    mode <= 3'h2;
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    #1;
    `CHK(capture_compare_value, 16'haa55)
    `CHK(flag, 1'b1)
    u_cpu.rd(OFS_CAPTURE_COMPARE_VALUE_LOW, v);
    `CHK(v, 8'h55)
    `CHK(flag, 1'b0)
    u_cpu.rd(OFS_CAPTURE_COMPARE_VALUE_HIGH, v);
    `CHK(v, 8'haa)
    // pwm mode: a lone high byte lands at once; low byte match sets the flag
    @(posedge clk);
    mode <= MODE_PWM8;
    u_cpu.wr(OFS_CAPTURE_COMPARE_VALUE_HIGH, 8'h77);
    #1;
    `CHK(capture_compare_value, 16'h7755)
    `CHK(flag, 1'b1)
    u_cpu.wr(OFS_CAPTURE_COMPARE_VALUE_LOW, 8'h11);
    #1;
    `CHK(capture_compare_value, 16'h7711)
    u_cpu.rd(OFS_CAPTURE_COMPARE_VALUE_HIGH, v);
    `CHK(v, 8'h77)
    give_verdict();
  end
endmodule : tb

// ---- testbench/tbcr_cpu_model.sv ----
// cpu side model: byte-wide register strobes of the timer registers
// assumes one clock; each request starts just after a rising edge
`timescale 1ns/100ps
module tbcr_cpu_model (
  input  wire logic       clk_in,
  output logic      [3:0] addr_out,
  output logic            wr_en_out,
  output logic            rd_en_out,
  output logic      [7:0] wdata_out,
  input  wire logic [7:0] rdata_in
);
  // idle levels from time zero
  initial begin
    addr_out = 4'h0;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    wdata_out = 8'h00;
  end
  // one-cycle write strobe; released data shows its inverse so stale values never match
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_en_out <= 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wdata_out <= ~d;
  endtask : wr
  // read data is registered, so it is taken just after the strobe's edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    #1 d = rdata_in;
  endtask : rd
endmodule : tbcr_cpu_model
